// [core/prog_select_params.svh]
// constants for the programmable chip-select decoder: ports, indexes, fields, resets
`ifndef PROG_SELECT_PARAMS_SVH
`define PROG_SELECT_PARAMS_SVH

// ****************************************
// configuration space access ports
// ****************************************
`define PSEL_INDEX_PORT 16'h0022
`define PSEL_DATA_PORT 16'h0024
`define PSEL_UNARMED_READ 8'hff
`define PSEL_UNMAPPED_READ 8'h00

// ****************************************
// register indexes
// ****************************************
`define PSEL_IDX_CYCLE_TYPE 8'hb3
`define PSEL_IDX_TWO_BASE 8'hba
`define PSEL_IDX_TWO_CONTROL 8'hbb
`define PSEL_IDX_THREE_BASE 8'hbc
`define PSEL_IDX_THREE_CONTROL 8'hbd
`define PSEL_IDX_GRANULARITY 8'hbf

// ****************************************
// reset values
// ****************************************
`define PSEL_RST_CYCLE_TYPE 8'h00
`define PSEL_RST_BASE 8'h00
`define PSEL_RST_CONTROL 8'h00
`define PSEL_RST_GRANULARITY 8'h0f

// ****************************************
// control register fields
// ****************************************
`define PSEL_CTRL_TOP_BASE 7
`define PSEL_CTRL_WRITE_EN 6
`define PSEL_CTRL_READ_EN 5
`define PSEL_CTRL_EARLY 4
`define PSEL_CTRL_MASK_HI 3
`define PSEL_CTRL_MASK_LO 0

// ****************************************
// shared register fields, select two then three
// ****************************************
`define PSEL_GRAN_BASE_TWO 6
`define PSEL_GRAN_BASE_THREE 7
`define PSEL_GRAN_MASK_TWO 2
`define PSEL_GRAN_MASK_THREE 3
`define PSEL_CT_ROM_TWO 2
`define PSEL_CT_ROM_THREE 3
`define PSEL_CT_WIDE_TWO 6
`define PSEL_CT_WIDE_THREE 7

// ****************************************
// shared pin lanes (pin six is lane 0)
// ****************************************
`define PSEL_LANE_TWO 2
`define PSEL_LANE_THREE 3

`endif

// [core/prog_select_pkg.sv]
// types shared by the programmable chip-select decoder files
package prog_select_pkg;

   // one select's decoded configuration
   typedef struct packed {
      logic [7:0] base;
      logic top_base;
      logic write_en;
      logic read_en;
      logic early;
      logic [3:0] mask;
      logic low_base;
      logic low_mask;
      logic is_rom;
      logic rom_wide;
   } sel_cfg_t;

   // one bus cycle as seen by the decoder
   typedef struct packed {
      logic [23:0] addr;
      logic mem;
      logic write;
      logic addr_valid;
      logic cmd;
   } bus_cycle_t;

   typedef enum logic {
      IDX_IDLE,
      IDX_ARMED
   } idx_state_t;

endpackage

// [core/prog_select_match.sv]
// address, cycle type and direction comparator for one programmable select
`timescale 1ns/1ps
`default_nettype none

module prog_select_match (
   input wire prog_select_pkg::sel_cfg_t cfg_i,
   input wire prog_select_pkg::bus_cycle_t cyc_i,
   output logic hit_o
);

   logic [9:0] field;
   logic [9:0] want;
   logic [9:0] care;
   logic type_ok;
   logic dir_ok;

   // ****************************************
   // pick the ten compared address bits
   // ****************************************
   always_comb begin
      if (cyc_i.mem) begin
         field = cyc_i.addr[23:14];
      end else begin
         field = cyc_i.addr[9:0];
      end
   end

   // top bit from control, eight from base, low from granularity
   assign want = {cfg_i.top_base, cfg_i.base, cfg_i.low_base};
   // a set mask bit drops that bit from the compare
   assign care = {5'h1f, ~cfg_i.mask, ~cfg_i.low_mask};

   // ****************************************
   // cycle qualification
   // ****************************************
   assign type_ok = (cyc_i.mem == cfg_i.is_rom);
   assign dir_ok = cyc_i.write ? cfg_i.write_en : cfg_i.read_en;

   assign hit_o = type_ok && dir_ok && (((field ^ want) & care) == 10'h000);

endmodule // prog_select_match

`default_nettype wire

// [core/prog_select_decoder.sv]
// programmable chip-select decoder for selects two and three, with its config registers
`timescale 1ns/1ps
`default_nettype none
`include "prog_select_params.svh"

module prog_select_decoder #(
   parameter int IO_ADDR_W = 16
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // configuration i/o port
   input wire logic [IO_ADDR_W-1:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   output logic io_rdata_valid_o,
   // bus cycle under decode
   input wire logic [23:0] cyc_addr_i,
   input wire logic cyc_mem_i,
   input wire logic cyc_write_i,
   input wire logic cyc_addr_valid_i,
   input wire logic cyc_cmd_i,
   // cycles that own the shared pins or forbid selects
   input wire logic dram_cycle_i,
   input wire logic cpu_hold_acknowledge_i,
   input wire logic [3:0] dram_addr_i,
   // pins and status
   output logic at_cycle_strobe_n_o,
   output logic [3:0] shared_mem_addr_pins_o,
   output logic prog_select_two_n_o,
   output logic prog_select_three_n_o,
   output logic rom_select_cycle_o,
   output logic rom_word_wide_o
);

   // ****************************************
   // elaboration checks
   // ****************************************
   generate
      if (IO_ADDR_W < 10 || IO_ADDR_W > 16) begin : g_bad_width
         $error("IO_ADDR_W must lie between 10 and 16");
      end
   endgenerate

   localparam int NSEL = 2;

   // ****************************************
   // declarations
   // ****************************************
   prog_select_pkg::idx_state_t idx_state;
   logic [7:0] idx_value;
   logic [7:0] cycle_type;
   logic [7:0] two_base;
   logic [7:0] two_control;
   logic [7:0] three_base;
   logic [7:0] three_control;
   logic [7:0] granularity;
   logic [15:0] io_addr_full;
   logic hit_index_port;
   logic hit_data_port;
   logic data_access;
   logic data_write;
   logic data_read;
   logic [7:0] next_rdata;
   prog_select_pkg::bus_cycle_t cyc;
   prog_select_pkg::sel_cfg_t cfg [NSEL];
   logic [NSEL-1:0] hit;
   logic [NSEL-1:0] timing_ok;
   logic [NSEL-1:0] next_sel;
   logic [NSEL-1:0] sel;
   logic blocked;
   logic next_strobe;
   logic strobe;
   logic [3:0] next_pins;
   logic next_rom;
   logic next_wide;

   // ****************************************
   // configuration port decode
   // ****************************************
   assign io_addr_full = 16'(io_addr_i);
   assign hit_index_port = (io_addr_full == `PSEL_INDEX_PORT);
   assign hit_data_port = (io_addr_full == `PSEL_DATA_PORT);
   assign data_access = hit_data_port && (io_wr_i || io_rd_i);
   // a data access only counts after a fresh index write
   assign data_write = hit_data_port && io_wr_i
                       && (idx_state == prog_select_pkg::IDX_ARMED);
   assign data_read = hit_data_port && io_rd_i
                      && (idx_state == prog_select_pkg::IDX_ARMED);

   // ****************************************
   // index state
   // ****************************************
   // the index disarms after every data access, so software
   // must rewrite it even for back-to-back use of one register
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         idx_state <= prog_select_pkg::IDX_IDLE;
      end else begin
         case (idx_state)
            prog_select_pkg::IDX_IDLE: begin
               if (hit_index_port && io_wr_i) begin
                  idx_state <= prog_select_pkg::IDX_ARMED;
               end
            end
            prog_select_pkg::IDX_ARMED: begin
               if (data_access) begin
                  idx_state <= prog_select_pkg::IDX_IDLE;
               end
            end
            default: begin
               idx_state <= prog_select_pkg::IDX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         idx_value <= 8'h00;
      end else if (hit_index_port && io_wr_i) begin
         idx_value <= io_wdata_i;
      end
   end

   // ****************************************
   // register writes
   // ****************************************
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cycle_type <= `PSEL_RST_CYCLE_TYPE;
         two_base <= `PSEL_RST_BASE;
         two_control <= `PSEL_RST_CONTROL;
         three_base <= `PSEL_RST_BASE;
         three_control <= `PSEL_RST_CONTROL;
         granularity <= `PSEL_RST_GRANULARITY;
      end else if (data_write) begin
         case (idx_value)
            `PSEL_IDX_CYCLE_TYPE: begin
               cycle_type <= io_wdata_i;
            end
            `PSEL_IDX_TWO_BASE: begin
               two_base <= io_wdata_i;
            end
            `PSEL_IDX_TWO_CONTROL: begin
               two_control <= io_wdata_i;
            end
            `PSEL_IDX_THREE_BASE: begin
               three_base <= io_wdata_i;
            end
            `PSEL_IDX_THREE_CONTROL: begin
               three_control <= io_wdata_i;
            end
            `PSEL_IDX_GRANULARITY: begin
               granularity <= io_wdata_i;
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // register reads
   // ****************************************
   always_comb begin
      next_rdata = `PSEL_UNMAPPED_READ;
      if (!data_read) begin
         next_rdata = `PSEL_UNARMED_READ;
      end else begin
         case (idx_value)
            `PSEL_IDX_CYCLE_TYPE: next_rdata = cycle_type;
            `PSEL_IDX_TWO_BASE: next_rdata = two_base;
            `PSEL_IDX_TWO_CONTROL: next_rdata = two_control;
            `PSEL_IDX_THREE_BASE: next_rdata = three_base;
            `PSEL_IDX_THREE_CONTROL: next_rdata = three_control;
            `PSEL_IDX_GRANULARITY: next_rdata = granularity;
            default: next_rdata = `PSEL_UNMAPPED_READ;
         endcase
      end
   end

   // read data is held until the next data-port read
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         io_rdata_o <= 8'h00;
         io_rdata_valid_o <= 1'b0;
      end else begin
         io_rdata_valid_o <= hit_data_port && io_rd_i;
         if (hit_data_port && io_rd_i) begin
            io_rdata_o <= next_rdata;
         end
      end
   end

   // ****************************************
   // per-select configuration
   // ****************************************
   always_comb begin
      cfg[0].base = two_base;
      cfg[0].top_base = two_control[`PSEL_CTRL_TOP_BASE];
      cfg[0].write_en = two_control[`PSEL_CTRL_WRITE_EN];
      cfg[0].read_en = two_control[`PSEL_CTRL_READ_EN];
      cfg[0].early = two_control[`PSEL_CTRL_EARLY];
      cfg[0].mask = two_control[`PSEL_CTRL_MASK_HI:`PSEL_CTRL_MASK_LO];
      cfg[0].low_base = granularity[`PSEL_GRAN_BASE_TWO];
      cfg[0].low_mask = granularity[`PSEL_GRAN_MASK_TWO];
      cfg[0].is_rom = cycle_type[`PSEL_CT_ROM_TWO];
      cfg[0].rom_wide = cycle_type[`PSEL_CT_WIDE_TWO];
      cfg[1].base = three_base;
      cfg[1].top_base = three_control[`PSEL_CTRL_TOP_BASE];
      cfg[1].write_en = three_control[`PSEL_CTRL_WRITE_EN];
      cfg[1].read_en = three_control[`PSEL_CTRL_READ_EN];
      cfg[1].early = three_control[`PSEL_CTRL_EARLY];
      cfg[1].mask = three_control[`PSEL_CTRL_MASK_HI:`PSEL_CTRL_MASK_LO];
      cfg[1].low_base = granularity[`PSEL_GRAN_BASE_THREE];
      cfg[1].low_mask = granularity[`PSEL_GRAN_MASK_THREE];
      cfg[1].is_rom = cycle_type[`PSEL_CT_ROM_THREE];
      cfg[1].rom_wide = cycle_type[`PSEL_CT_WIDE_THREE];
   end

   // ****************************************
   // bus cycle capture
   // ****************************************
   assign cyc.addr = cyc_addr_i;
   assign cyc.mem = cyc_mem_i;
   assign cyc.write = cyc_write_i;
   assign cyc.addr_valid = cyc_addr_valid_i;
   assign cyc.cmd = cyc_cmd_i;

   // ****************************************
   // decode per select
   // ****************************************
   generate
      for (genvar s = 0; s < NSEL; s++) begin : g_sel
         prog_select_match u_match (
            .cfg_i(cfg[s]),
            .cyc_i(cyc),
            .hit_o(hit[s])
         );
         // early mode fires on the address alone, otherwise waits for the command
         assign timing_ok[s] = cyc.addr_valid
                               && (cfg[s].early || cyc.cmd);
         assign next_sel[s] = hit[s] && timing_ok[s] && !blocked;
      end
   endgenerate

   // the shared pins belong to the memory controller on dram cycles, and
   // hold-acknowledge marks dma and refresh, where no peripheral may answer
   assign blocked = dram_cycle_i || cpu_hold_acknowledge_i;

   // ****************************************
   // select state
   // ****************************************
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel <= '0;
      end else begin
         sel <= next_sel;
      end
   end

   assign next_strobe = |next_sel;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         strobe <= 1'b0;
      end else begin
         strobe <= next_strobe;
      end
   end

   // ****************************************
   // shared pin multiplexer
   // ****************************************
   // the mux follows the strobe flop, so pins change one clock after the
   // strobe; downstream gating must tolerate that lag or delay the strobe
   always_comb begin
      next_pins = dram_addr_i;
      if (strobe) begin
         next_pins = 4'hf;
         next_pins[`PSEL_LANE_TWO] = !sel[0];
         next_pins[`PSEL_LANE_THREE] = !sel[1];
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shared_mem_addr_pins_o <= 4'h0;
      end else begin
         shared_mem_addr_pins_o <= next_pins;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         at_cycle_strobe_n_o <= 1'b1;
         prog_select_two_n_o <= 1'b1;
         prog_select_three_n_o <= 1'b1;
      end else begin
         at_cycle_strobe_n_o <= !next_strobe;
         prog_select_two_n_o <= !next_sel[0];
         prog_select_three_n_o <= !next_sel[1];
      end
   end

   // ****************************************
   // rom status
   // ****************************************
   // select two wins the width report if both hit the same rom cycle
   always_comb begin
      next_rom = 1'b0;
      next_wide = 1'b0;
      if (next_sel[0] && cfg[0].is_rom) begin
         next_rom = 1'b1;
         next_wide = cfg[0].rom_wide;
      end else if (next_sel[1] && cfg[1].is_rom) begin
         next_rom = 1'b1;
         next_wide = cfg[1].rom_wide;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rom_select_cycle_o <= 1'b0;
         rom_word_wide_o <= 1'b0;
      end else begin
         rom_select_cycle_o <= next_rom;
         rom_word_wide_o <= next_wide;
      end
   end

endmodule // prog_select_decoder

`default_nettype wire

// [sim/prog_select_glue_model.sv]
// board glue model: gates the decoder strobe with hold-acknowledge and the select lanes
`timescale 1ns/1ps
`default_nettype none

module prog_select_glue_model (
   input wire logic clk_i,
   input wire logic at_cycle_strobe_n_i,
   input wire logic cpu_hold_acknowledge_i,
   input wire logic addr_enable_i,
   input wire logic [3:0] shared_mem_addr_pins_i,
   output logic periph_two_n_o,
   output logic periph_three_n_o,
   output logic raw_two_n_o
);
   logic strobe_late_n = 1'b1;
   logic gate_n;
   // strobe delayed a cycle so the lanes have settled before gating, no transient
   always_ff @(posedge clk_i) begin
      strobe_late_n <= at_cycle_strobe_n_i;
   end
   // hold-acknowledge blocks, since the bus clock may be unrelated to the core clock
   assign gate_n = strobe_late_n | cpu_hold_acknowledge_i;
   assign periph_two_n_o = gate_n | shared_mem_addr_pins_i[2];
   assign periph_three_n_o = gate_n | shared_mem_addr_pins_i[3];
   // raw decode gated by address-enable; the peripheral also waits for its command, so a transient is harmless
   assign raw_two_n_o = at_cycle_strobe_n_i | addr_enable_i | shared_mem_addr_pins_i[2];
endmodule // prog_select_glue_model

`default_nettype wire

// [sim/prog_select_decoder_checker.sv]
// port assertions for the programmable chip-select decoder
`timescale 1ns/1ps
`default_nettype none
`include "prog_select_params.svh"

module prog_select_decoder_checker #(
   parameter int IO_ADDR_W = 16
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [IO_ADDR_W-1:0] io_addr_i,
   input wire logic io_rd_i,
   input wire logic io_rdata_valid_o,
   input wire logic cyc_mem_i,
   input wire logic cyc_addr_valid_i,
   input wire logic dram_cycle_i,
   input wire logic cpu_hold_acknowledge_i,
   input wire logic [3:0] dram_addr_i,
   input wire logic at_cycle_strobe_n_o,
   input wire logic [3:0] shared_mem_addr_pins_o,
   input wire logic prog_select_two_n_o,
   input wire logic prog_select_three_n_o,
   input wire logic rom_select_cycle_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   chk_dram_blocks_sel: assert property (dram_cycle_i |=> at_cycle_strobe_n_o)
      else $error("select active after a dram cycle");
   chk_hold_blocks_sel: assert property (cpu_hold_acknowledge_i |=> at_cycle_strobe_n_o)
      else $error("select active during hold-acknowledge");
   chk_strobe_any_sel: assert property (at_cycle_strobe_n_o == (prog_select_two_n_o && prog_select_three_n_o))
      else $error("strobe does not match the selects");
   // the first edge after release still shows the reset pin value, so the past cycle must be out of reset
   chk_pins_follow_dram: assert property ($past(nrst_i) && $past(at_cycle_strobe_n_o)
      |-> shared_mem_addr_pins_o == $past(dram_addr_i))
      else $error("shared pins not carrying dram value");
   chk_pins_carry_sel: assert property (!$past(at_cycle_strobe_n_o) |-> shared_mem_addr_pins_o ==
      {$past(prog_select_three_n_o), $past(prog_select_two_n_o), 2'b11})
      else $error("shared pins not carrying selects");
   chk_needs_addr_valid: assert property (!cyc_addr_valid_i |=> at_cycle_strobe_n_o)
      else $error("select without a valid address");
   chk_rom_needs_mem: assert property (rom_select_cycle_o |-> !at_cycle_strobe_n_o && $past(cyc_mem_i))
      else $error("rom select outside a memory select");
   chk_read_valid_pulse: assert property (io_rdata_valid_o == $past(io_rd_i && io_addr_i == IO_ADDR_W'(`PSEL_DATA_PORT)))
      else $error("read valid not one cycle after data read");
endmodule // prog_select_decoder_checker

bind prog_select_decoder prog_select_decoder_checker #(.IO_ADDR_W(IO_ADDR_W)) u_checker (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
   .io_rdata_valid_o(io_rdata_valid_o), .cyc_mem_i(cyc_mem_i), .cyc_addr_valid_i(cyc_addr_valid_i),
   .dram_cycle_i(dram_cycle_i), .cpu_hold_acknowledge_i(cpu_hold_acknowledge_i), .dram_addr_i(dram_addr_i),
   .at_cycle_strobe_n_o(at_cycle_strobe_n_o), .shared_mem_addr_pins_o(shared_mem_addr_pins_o),
   .prog_select_two_n_o(prog_select_two_n_o), .prog_select_three_n_o(prog_select_three_n_o),
   .rom_select_cycle_o(rom_select_cycle_o));

`default_nettype wire

// [sim/prog_select_decoder_tb_top.sv]
// self-checking bench for the programmable chip-select decoder
`timescale 1ns/1ps
`default_nettype none
`include "prog_select_params.svh"

module prog_select_decoder_tb_top;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [15:0] io_addr_i = 16'h0000;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [7:0] io_wdata_i = 8'h00;
   prog_select_pkg::bus_cycle_t cyc = '0;
   logic dram_cycle_i = 1'b0;
   logic cpu_hold_acknowledge_i = 1'b0;
   logic [3:0] dram_addr_i = 4'ha;
   logic [7:0] io_rdata_o;
   logic io_rdata_valid_o, at_cycle_strobe_n_o, prog_select_two_n_o, prog_select_three_n_o;
   logic rom_select_cycle_o, rom_word_wide_o, glue_two_n, glue_three_n, raw_two_n;
   logic [3:0] shared_mem_addr_pins_o;
   logic wide_exp = 1'b0;
   int miscompares = 0;
   int checks_done = 0;
   logic [7:0] idx_tab [6] = '{8'hb3, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbf};
   logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f};

   prog_select_decoder #(.IO_ADDR_W(16)) dut (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
      .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rdata_valid_o(io_rdata_valid_o),
      .cyc_addr_i(cyc.addr), .cyc_mem_i(cyc.mem), .cyc_write_i(cyc.write),
      .cyc_addr_valid_i(cyc.addr_valid), .cyc_cmd_i(cyc.cmd), .dram_cycle_i(dram_cycle_i),
      .cpu_hold_acknowledge_i(cpu_hold_acknowledge_i), .dram_addr_i(dram_addr_i),
      .at_cycle_strobe_n_o(at_cycle_strobe_n_o), .shared_mem_addr_pins_o(shared_mem_addr_pins_o),
      .prog_select_two_n_o(prog_select_two_n_o), .prog_select_three_n_o(prog_select_three_n_o),
      .rom_select_cycle_o(rom_select_cycle_o), .rom_word_wide_o(rom_word_wide_o));

   prog_select_glue_model glue (
      .clk_i(core_clk_i), .at_cycle_strobe_n_i(at_cycle_strobe_n_o),
      .cpu_hold_acknowledge_i(cpu_hold_acknowledge_i), .addr_enable_i(cpu_hold_acknowledge_i),
      .shared_mem_addr_pins_i(shared_mem_addr_pins_o),
      .periph_two_n_o(glue_two_n), .periph_three_n_o(glue_three_n), .raw_two_n_o(raw_two_n));

   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // ****************************************
   // check and report
   // ****************************************
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************************************
   // config port access
   // ****************************************
   task automatic io_access(input logic [15:0] a, input logic wr, input logic rd, input logic [7:0] d);
      @(posedge core_clk_i);
      io_addr_i <= a;
      io_wr_i <= wr;
      io_rd_i <= rd;
      io_wdata_i <= d;
      @(posedge core_clk_i);
      io_wr_i <= 1'b0;
      io_rd_i <= 1'b0;
   endtask

   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      io_access(`PSEL_INDEX_PORT, 1'b1, 1'b0, idx);
      io_access(`PSEL_DATA_PORT, 1'b1, 1'b0, d);
   endtask

   task automatic data_rd(input logic [7:0] exp);
      int i;
      io_access(`PSEL_DATA_PORT, 1'b0, 1'b1, 8'h00);
      // valid stands only in the cycle after the taking edge, so look right after that edge
      for (i = 0; i < 4; i++) begin
         #1;
         if (io_rdata_valid_o === 1'b1) break;
         @(posedge core_clk_i);
      end
      if (i == 4) begin
         miscompares++;
         $display("[ERR] read valid expected 1 seen 0");
         conclude();
      end else begin
         check("register read", io_rdata_o, exp);
      end
   endtask

   task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
      io_access(`PSEL_INDEX_PORT, 1'b1, 1'b0, idx);
      data_rd(exp);
   endtask

   // ****************************************
   // one bus cycle: drive, check the selects, release, check idle
   // ****************************************
   task automatic bus_cycle(input logic [23:0] a, input logic m, input logic w, input logic c, input logic [1:0] e);
      logic [3:0] pins;
      @(posedge core_clk_i);
      // taken after the edge so a pin value changed just before the call has landed
      pins = (e != 2'b00) ? {!e[1], !e[0], 2'b11} : dram_addr_i;
      cyc <= '{addr: a, mem: m, write: w, addr_valid: 1'b1, cmd: c};
      repeat (3) @(posedge core_clk_i);
      #1;
      check("select two", prog_select_two_n_o, !e[0]);
      check("select three", prog_select_three_n_o, !e[1]);
      check("strobe", at_cycle_strobe_n_o, !(|e));
      check("pins", shared_mem_addr_pins_o, pins);
      check("rom cycle", rom_select_cycle_o, m & (|e));
      if (m && e != 2'b00) check("rom wide", rom_word_wide_o, wide_exp);
      check("glue two", glue_two_n, !e[0] | cpu_hold_acknowledge_i);
      check("glue three", glue_three_n, !e[1] | cpu_hold_acknowledge_i);
      check("raw two", raw_two_n, !e[0] | cpu_hold_acknowledge_i);
      @(posedge core_clk_i);
      cyc <= '0;
      repeat (3) @(posedge core_clk_i);
      #1;
      check("idle pins", shared_mem_addr_pins_o, dram_addr_i);
      check("idle strobe", at_cycle_strobe_n_o, 1'b1);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      for (int i = 0; i < 6; i++) reg_rd(idx_tab[i], rst_tab[i]);
      data_rd(`PSEL_UNARMED_READ);
      reg_rd(8'h50, `PSEL_UNMAPPED_READ);
      for (int i = 0; i < 6; i++) reg_wr(idx_tab[i], idx_tab[i] ^ 8'h3c);
      for (int i = 0; i < 6; i++) reg_rd(idx_tab[i], idx_tab[i] ^ 8'h3c);
      $display("test config space done");
      reg_wr(8'hb3, 8'h00);
      reg_wr(8'hbf, 8'h0f);
      reg_wr(8'hbc, 8'h00);
      reg_wr(8'hbd, 8'h00);
      reg_wr(8'hba, 8'h80);
      reg_wr(8'hbb, 8'ha0);
      bus_cycle(24'h000300, 1'b0, 1'b0, 1'b1, 2'b01);
      bus_cycle(24'h000300, 1'b0, 1'b0, 1'b0, 2'b00);
      bus_cycle(24'h000300, 1'b0, 1'b1, 1'b1, 2'b00);
      bus_cycle(24'h000100, 1'b0, 1'b0, 1'b1, 2'b00);
      bus_cycle(24'h000340, 1'b0, 1'b0, 1'b1, 2'b00);
      bus_cycle(24'h000301, 1'b0, 1'b0, 1'b1, 2'b01);
      bus_cycle(24'h000302, 1'b0, 1'b0, 1'b1, 2'b00);
      reg_wr(8'hbb, 8'haf);
      bus_cycle(24'h00031e, 1'b0, 1'b0, 1'b1, 2'b01);
      reg_wr(8'hbb, 8'hf0);
      bus_cycle(24'h000300, 1'b0, 1'b1, 1'b0, 2'b01);
      reg_wr(8'hbf, 8'h40);
      bus_cycle(24'h000300, 1'b0, 1'b0, 1'b1, 2'b00);
      bus_cycle(24'h000301, 1'b0, 1'b0, 1'b1, 2'b01);
      $display("test io decode done");
      dram_addr_i <= 4'h5;
      dram_cycle_i <= 1'b1;
      bus_cycle(24'h000301, 1'b0, 1'b0, 1'b1, 2'b00);
      dram_cycle_i <= 1'b0;
      cpu_hold_acknowledge_i <= 1'b1;
      bus_cycle(24'h000301, 1'b0, 1'b0, 1'b1, 2'b00);
      cpu_hold_acknowledge_i <= 1'b0;
      $display("test blocking done");
      reg_wr(8'hb3, 8'h88);
      reg_wr(8'hbc, 8'h12);
      reg_wr(8'hbd, 8'h20);
      wide_exp = 1'b1;
      bus_cycle(24'h090000, 1'b1, 1'b0, 1'b1, 2'b10);
      reg_wr(8'hb3, 8'h08);
      wide_exp = 1'b0;
      bus_cycle(24'h090000, 1'b1, 1'b0, 1'b1, 2'b10);
      bus_cycle(24'h000024, 1'b0, 1'b0, 1'b1, 2'b00);
      bus_cycle(24'h094000, 1'b1, 1'b0, 1'b1, 2'b00);
      $display("test rom select done");
      conclude();
   end
endmodule // prog_select_decoder_tb_top

`default_nettype wire
